// ### shared/psbs_defs.svh
// Offsets, field positions, widths and counts for the burst bus sequencer.
// Assumes nothing of its surroundings; it holds definitions only.
`ifndef PSBS_DEFS_SVH
`define PSBS_DEFS_SVH

// Width of the multiplexed address/data bus.
`define PSBS_DQ_W 16
// Address bits of the storage array that the block keeps.
`define PSBS_MEM_AW 8
// Address bits inside one row; a row ends where these bits are all ones.
`define PSBS_ROW_AW 7
// Depth of the read-data FIFO.
`define PSBS_FIFO_DEPTH 16
// Width of the latency code field.
`define PSBS_LC_W 3
// Width of the latency counter; it must hold twice the largest code.
`define PSBS_LAT_W 4
// Width of the word counter of a burst.
`define PSBS_CNT_W 5
// Shift that doubles the latency count on a refresh collision.
`define PSBS_COLLIDE_SHIFT 1

// Burst length codes.
`define PSBS_LEN_4 2'h0
`define PSBS_LEN_8 2'h1
`define PSBS_LEN_16 2'h2
`define PSBS_LEN_CONT 2'h3

// Address masks of the fixed burst lengths, which are also length minus one.
`define PSBS_MASK_4 4'h3
`define PSBS_MASK_8 4'h7
`define PSBS_MASK_16 4'hf
`define PSBS_MASK_NONE 4'h0

// Bit positions of the pins inside the synchroniser vector.
`define PSBS_PIN_CE 0
`define PSBS_PIN_ADV 1
`define PSBS_PIN_OE 2
`define PSBS_PIN_WE 3
`define PSBS_PIN_UB 4
`define PSBS_PIN_LB 5
`define PSBS_PIN_CLK 6
`define PSBS_PIN_DQ 7
// Number of control pins ahead of the bus in the synchroniser vector.
`define PSBS_PIN_CTRL_W 7

`endif

// ### shared/psbs_pkg.sv
// Types shared by the burst bus sequencer modules.
// Assumes the constants header is available to the files that need numbers.
package psbs_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    PSBS_ST_IDLE = 3'h0,
    PSBS_ST_LAT = 3'h1,
    PSBS_ST_DATA = 3'h2,
    PSBS_ST_DONE = 3'h3,
    PSBS_ST_EOR = 3'h4
  } psbs_state_t;

endpackage

// ### shared/psbs_stream_if.sv
// Stream carrier between the sequencer and its read-data FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface psbs_stream_if #(
  parameter int WIDTH = 16
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic flush;

  // The FIFO end.
  modport fifo (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );

  // The user end, which both fills and drains.
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data
  );
endinterface

// ### core/psbs_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a flush input.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module psbs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  psbs_stream_if.fifo s
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;

  // Full when the pointers differ only in the wrap bit; empty when equal.
  wire ptr_same = (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  wire is_empty = ptr_same & (wr_ptr_reg[PW] == rd_ptr_reg[PW]);
  wire is_full = ptr_same & (wr_ptr_reg[PW] != rd_ptr_reg[PW]);
  wire push_fire = s.push_valid & ~is_full;
  wire pop_fire = s.pop_ready & ~is_empty;

  // Handshake and head word.
  assign s.push_ready = ~is_full & ~s.flush;
  assign s.pop_valid = ~is_empty;
  assign s.pop_data = store[rd_ptr_reg[PW-1:0]];

  // Pointer update; a flush empties the FIFO at once.
  always_ff @(posedge clock_i) begin
    if (rst_i || s.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop_fire) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Storage write.
  always_ff @(posedge clock_i) begin
    if (push_fire && !s.flush) begin
      store[wr_ptr_reg[PW-1:0]] <= s.push_data;
    end
  end
endmodule

// ### core/psbs_device.sv
// Device-side sequencer of a pseudo-static DRAM with a multiplexed
// address/data bus: asynchronous reads and writes, clocked bursts,
// wait generation, burst suspend and end-of-row handling.
// Assumes all bus pins come from outside the clock domain and that the
// configuration ports come from logic on clock_i.
//
// Contract
// R1: Variable-latency read colliding with refresh holds wait longer, at most twice latency code.
// R2: Controller keeps burst clock static without rising edges during read suspend.
// R3: With output enable low during suspend, valid data stays driven on the bus.
// R4: At row end with wrap off, controller drops select within three or four clocks.
// R5: Asynchronous write ends at first deassertion of select, byte enables or write enable.
// R6: Controller keeps write enable low no longer than maximum select pulse time.
// R7: In asynchronous writes wait floats while write enable is low or output enable high.
// R8: Burst write asserts wait for exactly the latency code count of clocks.
// R9: Controller meets address setup when select setup to clock exceeds threshold.
// R10: Controller drops select between asynchronous write and variable-latency burst read.
// R11: Controller drops select at least once every maximum select pulse time.
// R12: Controller may keep select low between async operations, else honours minimum high time.
// R13: With select held low, minimum high time only follows select-ended writes.
// R14: Burst latency is one clock more than the programmed latency code.
// R15: Write enable sampled at burst start chooses read when high, write when low.
// R16: Controller keeps any burst or mixed select assertion within maximum pulse width.
// R17: Controller keeps select high for minimum gap between async cycles.
// R18: Address captured while address valid is low, latched on its rise or clock edge.
// R19: After latency a read burst gives one word per clock edge until done or deselected.
`timescale 1ns/1ns
`include "psbs_defs.svh"
module psbs_device
  import psbs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic address_valid_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_enable_n_i,
  input wire logic upper_byte_enable_n_i,
  input wire logic lower_byte_enable_n_i,
  input wire logic burst_clock_i,
  input wire logic [`PSBS_DQ_W-1:0] muxed_addr_data_bus_i,
  output logic [`PSBS_DQ_W-1:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe_o,
  output logic wait_n_o,
  output logic wait_oe_o,
  input wire logic sync_mode_i,
  input wire logic fixed_latency_i,
  input wire logic [`PSBS_LC_W-1:0] latency_code_i,
  input wire logic wait_timing_i,
  input wire logic burst_wrap_i,
  input wire logic [1:0] burst_length_i,
  input wire logic refresh_collision_i,
  output logic burst_active_o
);
  localparam int AW = `PSBS_MEM_AW;
  localparam int DW = `PSBS_DQ_W;
  localparam int PIN_W = `PSBS_PIN_CTRL_W + `PSBS_DQ_W;
  localparam int DEPTH = 1 << AW;

  // Two-stage synchroniser for every pin; only the second stage is read.
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_meta_reg <= {PIN_W{1'b1}};
      pin_sync_reg <= {PIN_W{1'b1}};
    end else begin
      pin_meta_reg <= {muxed_addr_data_bus_i, burst_clock_i, lower_byte_enable_n_i, upper_byte_enable_n_i,
                       write_enable_n_i, output_enable_n_i, address_valid_n_i, chip_select_n_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Named views of the synchronised pins.
  wire ce_n = pin_sync_reg[`PSBS_PIN_CE];
  wire adv_n = pin_sync_reg[`PSBS_PIN_ADV];
  wire oe_n = pin_sync_reg[`PSBS_PIN_OE];
  wire we_n = pin_sync_reg[`PSBS_PIN_WE];
  wire ub_n = pin_sync_reg[`PSBS_PIN_UB];
  wire lb_n = pin_sync_reg[`PSBS_PIN_LB];
  wire bclk = pin_sync_reg[`PSBS_PIN_CLK];
  wire [DW-1:0] bus_in = pin_sync_reg[PIN_W-1:`PSBS_PIN_DQ];
  wire [1:0] be_now = {~ub_n, ~lb_n};

  // Edge detection on the synchronised burst clock and address valid.
  logic bclk_prev_reg;
  logic adv_prev_reg;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bclk_prev_reg <= 1'b1;
      adv_prev_reg <= 1'b1;
    end else begin
      bclk_prev_reg <= bclk;
      adv_prev_reg <= adv_n;
    end
  end
  wire clk_rise = bclk & ~bclk_prev_reg;
  wire adv_rise = adv_n & ~adv_prev_reg;

  // Burst length decode: address mask, continuous flag and effective wrap.
  wire cont = (burst_length_i == `PSBS_LEN_CONT);
  wire [3:0] len_mask = (burst_length_i == `PSBS_LEN_4) ? `PSBS_MASK_4 :
                        (burst_length_i == `PSBS_LEN_8) ? `PSBS_MASK_8 :
                        (burst_length_i == `PSBS_LEN_16) ? `PSBS_MASK_16 : `PSBS_MASK_NONE;
  wire wrap_eff = burst_wrap_i & ~cont;

  // Next burst address: wraps inside the burst length or counts on linearly.
  function automatic logic [AW-1:0] psbs_step(input logic [AW-1:0] a, input logic [3:0] m,
                                              input logic w);
    logic [AW-1:0] inc;
    logic [AW-1:0] mk;
    inc = a + 1'b1;
    mk = {{(AW-4){1'b0}}, m};
    psbs_step = w ? ((a & ~mk) | (inc & mk)) : inc;
  endfunction

  // Storage array.
  logic [DW-1:0] mem [0:DEPTH-1];

  // Asynchronous address path: follow the bus while address valid is low,
  // latch on its rising edge so the later data phase cannot disturb it.
  logic [AW-1:0] addr_cap_reg;
  logic [AW-1:0] addr_reg;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_cap_reg <= '0;
      addr_reg <= '0;
    end else begin
      if (!adv_n && !ce_n) begin
        addr_cap_reg <= bus_in[AW-1:0]; // R18
      end
      if (adv_rise && !ce_n) begin
        addr_reg <= addr_cap_reg; // R18
      end
    end
  end

  // Burst sequencer registers.
  psbs_state_t state_reg;
  psbs_state_t state_next;
  logic [`PSBS_LAT_W-1:0] lat_cnt_reg;
  logic [`PSBS_LAT_W-1:0] lat_cnt_next;
  logic [`PSBS_LAT_W-1:0] lat_target_reg;
  logic [`PSBS_LAT_W-1:0] lat_target_next;
  logic [`PSBS_CNT_W-1:0] word_cnt_reg;
  logic [`PSBS_CNT_W-1:0] word_cnt_next;
  logic [AW-1:0] bus_addr_reg;
  logic [AW-1:0] bus_addr_next;
  logic dir_read_reg;
  logic dir_read_next;
  logic data_step;
  logic burst_start;

  // Latency targets: collisions double the count on variable-latency reads only.
  wire [`PSBS_LAT_W-1:0] lat_plain = {1'b0, latency_code_i};
  wire [`PSBS_LAT_W-1:0] lat_doubled = {1'b0, latency_code_i} << `PSBS_COLLIDE_SHIFT;
  wire collide = we_n & ~fixed_latency_i & refresh_collision_i;
  wire last_word = ~cont & (word_cnt_reg == {1'b0, len_mask});
  wire row_end = (&bus_addr_reg[`PSBS_ROW_AW-1:0]) & ~wrap_eff;

  // Next-state logic; every step of the sequence waits for a burst clock edge,
  // so a stopped clock freezes the burst where it stands.
  always_comb begin
    state_next = state_reg;
    lat_cnt_next = lat_cnt_reg;
    lat_target_next = lat_target_reg;
    word_cnt_next = word_cnt_reg;
    bus_addr_next = bus_addr_reg;
    dir_read_next = dir_read_reg;
    data_step = 1'b0;
    burst_start = 1'b0;
    if (ce_n) begin
      state_next = PSBS_ST_IDLE;
    end else if (clk_rise) begin
      case (state_reg)
        PSBS_ST_IDLE: begin
          if (!adv_n && sync_mode_i) begin
            burst_start = 1'b1;
            state_next = PSBS_ST_LAT;
            lat_cnt_next = '0;
            word_cnt_next = '0;
            bus_addr_next = bus_in[AW-1:0]; // R18
            dir_read_next = we_n; // R15
            lat_target_next = collide ? lat_doubled : lat_plain; // R1 R8
          end
        end
        PSBS_ST_LAT: begin
          if (lat_cnt_reg == lat_target_reg) begin
            data_step = 1'b1; // R14
          end else begin
            lat_cnt_next = lat_cnt_reg + 1'b1;
          end
        end
        PSBS_ST_DATA: begin
          data_step = 1'b1; // R19
        end
        PSBS_ST_DONE: begin
          state_next = PSBS_ST_DONE;
        end
        PSBS_ST_EOR: begin
          state_next = PSBS_ST_EOR;
        end
        default: begin
          state_next = PSBS_ST_IDLE;
        end
      endcase
      // One word moves per edge; the burst stops at its length or the row end.
      if (data_step) begin
        word_cnt_next = word_cnt_reg + 1'b1;
        bus_addr_next = psbs_step(bus_addr_reg, len_mask, wrap_eff);
        if (last_word) begin
          state_next = PSBS_ST_DONE; // R19
        end else if (row_end) begin
          state_next = PSBS_ST_EOR;
        end else begin
          state_next = PSBS_ST_DATA;
        end
      end
    end
  end

  // Sequencer state update.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= PSBS_ST_IDLE;
      lat_cnt_reg <= '0;
      lat_target_reg <= '0;
      word_cnt_reg <= '0;
      bus_addr_reg <= '0;
      dir_read_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      lat_cnt_reg <= lat_cnt_next;
      lat_target_reg <= lat_target_next;
      word_cnt_reg <= word_cnt_next;
      bus_addr_reg <= bus_addr_next;
      dir_read_reg <= dir_read_next;
    end
  end

  // Read-data FIFO between the array prefetch and the bus.
  psbs_stream_if #(.WIDTH(DW)) rd_stream ();
  psbs_fifo #(
    .WIDTH(DW),
    .DEPTH(`PSBS_FIFO_DEPTH)
  ) u_rd_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .s(rd_stream.fifo)
  );

  // Prefetch state: fills the FIFO ahead of the bus, stalls when it is full.
  logic fill_on_reg;
  logic [AW-1:0] fill_addr_reg;
  logic [`PSBS_CNT_W-1:0] fill_cnt_reg;
  wire push_fire = fill_on_reg & rd_stream.push_ready;
  wire fill_last = (~cont & (fill_cnt_reg == {1'b0, len_mask})) |
                   ((&fill_addr_reg[`PSBS_ROW_AW-1:0]) & ~wrap_eff);
  wire burst_rd_pop = data_step & dir_read_reg;
  wire burst_wr = data_step & ~dir_read_reg;

  // FIFO hookup; a new burst or a deselect throws away stale words.
  assign rd_stream.push_valid = fill_on_reg;
  assign rd_stream.push_data = mem[fill_addr_reg];
  assign rd_stream.pop_ready = burst_rd_pop;
  assign rd_stream.flush = ce_n | burst_start;

  // Prefetch address walk.
  always_ff @(posedge clock_i) begin
    if (rst_i || ce_n) begin
      fill_on_reg <= 1'b0;
      fill_addr_reg <= '0;
      fill_cnt_reg <= '0;
    end else if (burst_start && we_n) begin
      fill_on_reg <= 1'b1;
      fill_addr_reg <= bus_in[AW-1:0];
      fill_cnt_reg <= '0;
    end else if (push_fire) begin
      fill_addr_reg <= psbs_step(fill_addr_reg, len_mask, wrap_eff);
      fill_cnt_reg <= fill_cnt_reg + 1'b1;
      if (fill_last) begin
        fill_on_reg <= 1'b0;
      end
    end
  end

  // Asynchronous write tracking; the cycle is live while the sequencer is idle
  // and select, write enable and at least one byte enable are all low.
  logic aw_prev_reg;
  logic [1:0] aw_be_reg;
  logic [DW-1:0] aw_data_reg;
  wire aw_active = ~ce_n & ~we_n & (|be_now) & (state_reg == PSBS_ST_IDLE);
  wire aw_end = aw_prev_reg & (~aw_active | (|(aw_be_reg & ~be_now))); // R5
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_prev_reg <= 1'b0;
      aw_be_reg <= 2'h0;
      aw_data_reg <= '0;
    end else begin
      aw_prev_reg <= aw_active;
      if (aw_active) begin
        aw_be_reg <= be_now;
        aw_data_reg <= bus_in;
      end
    end
  end

  // Single array write port shared by burst and asynchronous writes.
  wire wr_en = aw_end | burst_wr;
  wire [AW-1:0] wr_addr = burst_wr ? bus_addr_reg : addr_reg;
  wire [DW-1:0] wr_data = burst_wr ? bus_in : aw_data_reg;
  wire [1:0] wr_be = burst_wr ? be_now : aw_be_reg;
  always_ff @(posedge clock_i) begin
    if (wr_en && wr_be[0]) begin
      mem[wr_addr][7:0] <= wr_data[7:0];
    end
    if (wr_en && wr_be[1]) begin
      mem[wr_addr][15:8] <= wr_data[15:8];
    end
  end

  // Output data register: burst words on each edge, array word when idle.
  // It holds between edges, so a suspended burst keeps its word on the bus.
  logic [DW-1:0] dout_reg;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dout_reg <= '0;
    end else if (burst_rd_pop && rd_stream.pop_valid) begin
      dout_reg <= rd_stream.pop_data; // R19
    end else if (state_reg == PSBS_ST_IDLE) begin
      dout_reg <= mem[addr_reg];
    end
  end

  // Bus drive: asynchronous reads, or a read burst past its latency.
  wire burst_busy = (state_reg != PSBS_ST_IDLE);
  wire burst_rd_out = dir_read_reg & ((state_reg == PSBS_ST_DATA) | (state_reg == PSBS_ST_DONE) |
                                      (state_reg == PSBS_ST_EOR));
  wire async_rd = ~sync_mode_i & (state_reg == PSBS_ST_IDLE);
  assign muxed_addr_data_bus_o = dout_reg;
  assign muxed_addr_data_bus_oe_o = ~ce_n & ~oe_n & we_n & (burst_rd_out | async_rd); // R3

  // Wait: asserted during the latency count and while parked at a row end;
  // the timing bit keeps it one clock longer.
  wire [`PSBS_LAT_W:0] wait_limit = {1'b0, lat_target_reg} + {{`PSBS_LAT_W{1'b0}}, wait_timing_i};
  wire wait_lat = (state_reg == PSBS_ST_LAT) & ({1'b0, lat_cnt_reg} < wait_limit); // R1 R8 R14
  wire wait_on = wait_lat | (state_reg == PSBS_ST_EOR);
  assign wait_n_o = ~wait_on;
  assign wait_oe_o = ~ce_n & (burst_busy | (~oe_n & we_n)); // R7
  assign burst_active_o = burst_busy;
endmodule

// ### verification/psbs_burst_monitor.sv
// Concurrent checks on the pins and status of the burst bus sequencer.
// Assumes it is bound to psbs_device and sees only that module's ports.
`timescale 1ns/1ns
`include "psbs_defs.svh"
module psbs_burst_monitor (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_enable_n_i,
  input wire logic burst_clock_i,
  input wire logic [`PSBS_LC_W-1:0] latency_code_i,
  input wire logic [`PSBS_DQ_W-1:0] muxed_addr_data_bus_o,
  input wire logic muxed_addr_data_bus_oe_o,
  input wire logic wait_n_o,
  input wire logic wait_oe_o,
  input wire logic burst_active_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Select held high long enough to pass the pin synchronisers.
  sequence s_desel;
    chip_select_n_i [*5];
  endsequence

  // A burst with output enabled and the burst clock held still.
  sequence s_still;
    (burst_active_o && !output_enable_n_i && $stable(burst_clock_i)) [*6];
  endsequence

  a_idle_wait_high: assert property (!burst_active_o |-> wait_n_o)
    else $error("wait asserted outside a burst");
  a_start_wait_low: assert property ($rose(burst_active_o) && latency_code_i != 3'h0 |-> !wait_n_o)
    else $error("wait not asserted at burst start");
  a_deselect_idle: assert property (s_desel |-> !burst_active_o)
    else $error("burst still active after deselect");
  a_deselect_float: assert property (s_desel |-> !wait_oe_o && !muxed_addr_data_bus_oe_o)
    else $error("pins driven while deselected");
  a_oe_high_float: assert property (output_enable_n_i [*5] |-> !muxed_addr_data_bus_oe_o)
    else $error("bus driven with output enable high");
  a_write_wait_float: assert property ((!burst_active_o && !write_enable_n_i) [*5] |-> !wait_oe_o)
    else $error("wait driven during asynchronous write");
  a_oe_wait_float: assert property ((!burst_active_o && output_enable_n_i) [*5] |-> !wait_oe_o)
    else $error("wait driven with output enable high");
  a_suspend_data_hold: assert property (s_still |-> $stable(muxed_addr_data_bus_o))
    else $error("read data changed during suspend");
endmodule

bind psbs_device psbs_burst_monitor psbs_burst_monitor_inst (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .chip_select_n_i(chip_select_n_i),
  .output_enable_n_i(output_enable_n_i),
  .write_enable_n_i(write_enable_n_i),
  .burst_clock_i(burst_clock_i),
  .latency_code_i(latency_code_i),
  .muxed_addr_data_bus_o(muxed_addr_data_bus_o),
  .muxed_addr_data_bus_oe_o(muxed_addr_data_bus_oe_o),
  .wait_n_o(wait_n_o),
  .wait_oe_o(wait_oe_o),
  .burst_active_o(burst_active_o)
);

// ### verification/psbs_ctrl_model.sv
// Behavioural system memory controller driving the device pins.
// Assumes the device bus output and its enable are fed back to resolve the bus.
`timescale 1ns/1ns
`include "psbs_defs.svh"
module psbs_ctrl_model (
  input wire logic clock_i,
  input wire logic [`PSBS_DQ_W-1:0] dev_data_i,
  input wire logic dev_oe_i,
  input wire logic wait_n_i,
  output logic chip_select_n_o,
  output logic address_valid_n_o,
  output logic output_enable_n_o,
  output logic write_enable_n_o,
  output logic [1:0] byte_enable_n_o,
  output logic burst_clock_o,
  output logic [`PSBS_DQ_W-1:0] bus_o
);
  logic drive;
  logic [`PSBS_DQ_W-1:0] val;

  // A released bus shows the inverse of the last value, never a stale copy.
  assign bus_o = dev_oe_i ? dev_data_i : (drive ? val : ~val);

  // Idle pins at time zero.
  initial begin
    {chip_select_n_o, address_valid_n_o, output_enable_n_o, write_enable_n_o} = 4'hf;
    byte_enable_n_o = 2'h3;
    burst_clock_o = 1'b0;
    drive = 1'b0;
    val = 16'h0000;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Select and address valid low with the address on the bus.
  task automatic addr_phase(input logic [15:0] a, input logic we_n);
    chip_select_n_o = 1'b0;
    address_valid_n_o = 1'b0;
    write_enable_n_o = we_n;
    drive = 1'b1;
    val = a;
    step(4);
  endtask

  // One burst clock period; the pin is slow against the system clock.
  task automatic bclk_pulse();
    burst_clock_o = 1'b1;
    step(4);
    burst_clock_o = 1'b0;
    step(4);
  endtask

  // Write ended by write enable rising; select then stays high for a gap.
  task automatic async_write(input logic [15:0] a, input logic [15:0] d);
    addr_phase(a, 1'b1);
    address_valid_n_o = 1'b1;
    step(4);
    write_enable_n_o = 1'b0;
    byte_enable_n_o = 2'h0;
    val = d;
    step(6);
    write_enable_n_o = 1'b1;
    step(4);
    byte_enable_n_o = 2'h3;
    drive = 1'b0;
    chip_select_n_o = 1'b1;
    step(6);
  endtask

  task automatic async_read(input logic [15:0] a, output logic [15:0] d);
    addr_phase(a, 1'b1);
    address_valid_n_o = 1'b1;
    drive = 1'b0;
    output_enable_n_o = 1'b0;
    step(8);
    d = dev_data_i;
    output_enable_n_o = 1'b1;
    chip_select_n_o = 1'b1;
    step(6);
  endtask

  // Burst of n words; counts edges seen with wait low, may suspend after two words.
  task automatic burst(input logic we_n, input logic [15:0] a, input int n, input logic [63:0] wd,
      input logic susp, input logic wt, output int waits, output logic [63:0] rd, output logic ok,
      output logic eor_wait);
    int g;
    int k;
    logic [15:0] held;
    waits = 0;
    k = 0;
    ok = 1'b1;
    rd = 64'h0;
    addr_phase(a, we_n);
    byte_enable_n_o = 2'h0;
    bclk_pulse();
    address_valid_n_o = 1'b1;
    drive = !we_n;
    output_enable_n_o = !we_n;
    for (g = 0; g < 40 && k < n; g++) begin
      val = wd[16*k +: 16];
      if (wait_n_i === 1'b0) begin
        waits++;
        bclk_pulse();
        // With the late wait timing the last waited edge already moved the first word.
        if (wt && k == 0 && wait_n_i === 1'b1) begin
          rd[15:0] = dev_data_i;
          k = 1;
        end
      end else begin
        bclk_pulse();
        rd[16*k +: 16] = dev_data_i;
        k++;
        if (susp && k == 2) begin
          held = dev_data_i;
          step(20);
          if (dev_data_i !== held) ok = 1'b0;
        end
      end
    end
    if (k < n) ok = 1'b0;
    step(2);
    eor_wait = wait_n_i;
    {chip_select_n_o, address_valid_n_o, output_enable_n_o, write_enable_n_o} = 4'hf;
    byte_enable_n_o = 2'h3;
    drive = 1'b0;
    step(8);
  endtask
endmodule

// ### verification/psbs_device_tb_top.sv
// Self-checking bench for the burst bus sequencer.
// Assumes the controller model and the bound monitor are compiled alongside.
`timescale 1ns/1ns
`include "psbs_defs.svh"
module psbs_device_tb_top;
  logic clock_i, rst_i, ce_n, adv_n, oe_n, we_n, bclk, bus_oe, wait_n, wait_oe, active;
  logic sync_mode, fixed_lat, wait_tm, wrap, collide;
  logic [1:0] be_n, blen;
  logic [2:0] lat_code;
  logic [15:0] bus_in, bus_out, d;
  int miscompares = 0;
  int check_count = 0;
  localparam logic [63:0] WA = 64'h4444_3333_2222_1111;
  localparam logic [63:0] WB = 64'h0000_0000_beef_c0de;

  psbs_device psbs_device_inst (.clock_i(clock_i), .rst_i(rst_i), .chip_select_n_i(ce_n),
    .address_valid_n_i(adv_n), .output_enable_n_i(oe_n), .write_enable_n_i(we_n),
    .upper_byte_enable_n_i(be_n[1]), .lower_byte_enable_n_i(be_n[0]), .burst_clock_i(bclk),
    .muxed_addr_data_bus_i(bus_in), .muxed_addr_data_bus_o(bus_out), .muxed_addr_data_bus_oe_o(bus_oe),
    .wait_n_o(wait_n), .wait_oe_o(wait_oe), .sync_mode_i(sync_mode), .fixed_latency_i(fixed_lat),
    .latency_code_i(lat_code), .wait_timing_i(wait_tm), .burst_wrap_i(wrap), .burst_length_i(blen),
    .refresh_collision_i(collide), .burst_active_o(active));

  psbs_ctrl_model psbs_ctrl_model_inst (.clock_i(clock_i), .dev_data_i(bus_out), .dev_oe_i(bus_oe),
    .wait_n_i(wait_n), .chip_select_n_o(ce_n), .address_valid_n_o(adv_n), .output_enable_n_o(oe_n),
    .write_enable_n_o(we_n), .byte_enable_n_o(be_n), .burst_clock_o(bclk), .bus_o(bus_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cfg(input logic sm, fl, input logic [2:0] lc, input logic wt, wr, input logic [1:0] bl,
      input logic co);
    @(posedge clock_i);
    #1;
    {sync_mode, fixed_lat, lat_code, wait_tm, wrap, blen, collide} = {sm, fl, lc, wt, wr, bl, co};
  endtask

  // Runs one burst and compares latency, suspend hold, read words and row-end wait.
  task automatic run_burst(input logic wn, input logic [15:0] a, input int n, input logic susp,
      input int exp_waits, input logic [63:0] exp_rd, input logic exp_eor);
    int waits;
    logic [63:0] rd;
    logic ok;
    logic ew;
    int i;
    psbs_ctrl_model_inst.burst(wn, a, n, exp_rd, susp, wait_tm, waits, rd, ok, ew);
    chk(16'(waits), 16'(exp_waits));
    chk({15'h0, ok}, 16'h0001);
    if (wn) for (i = 0; i < n; i++) chk(rd[16*i +: 16], exp_rd[16*i +: 16]);
    if (exp_eor) chk({15'h0, ew}, 16'h0000);
  endtask

  // Free-running system clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Hang guard.
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    {sync_mode, fixed_lat, lat_code, wait_tm, wrap, blen, collide} = 10'h000;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    psbs_ctrl_model_inst.async_write(16'h0012, 16'ha5c3);
    psbs_ctrl_model_inst.async_read(16'h0012, d);
    chk(d, 16'ha5c3);
    $display("test async done");
    cfg(1'b1, 1'b1, 3'h2, 1'b0, 1'b1, 2'h0, 1'b0);
    run_burst(1'b0, 16'h0020, 4, 1'b0, 2, WA, 1'b0);
    cfg(1'b1, 1'b0, 3'h2, 1'b0, 1'b1, 2'h0, 1'b1);
    run_burst(1'b1, 16'h0020, 4, 1'b0, 4, WA, 1'b0);
    cfg(1'b1, 1'b1, 3'h3, 1'b1, 1'b1, 2'h0, 1'b0);
    run_burst(1'b1, 16'h0020, 4, 1'b1, 4, WA, 1'b0);
    $display("test burst done");
    cfg(1'b1, 1'b0, 3'h3, 1'b0, 1'b0, 2'h3, 1'b1);
    run_burst(1'b0, 16'h007e, 2, 1'b0, 3, WB, 1'b1);
    cfg(1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 1'b0);
    psbs_ctrl_model_inst.async_read(16'h007f, d);
    chk(d, 16'hbeef);
    cfg(1'b1, 1'b1, 3'h2, 1'b0, 1'b0, 2'h3, 1'b0);
    run_burst(1'b1, 16'h007e, 2, 1'b0, 2, WB, 1'b1);
    chk({15'h0, active}, 16'h0000);
    $display("test end of row done");
    end_sim();
  end
endmodule
